// >>> loop_status_pkg.sv
// constants and types for the loop operating status block
package loop_status_pkg;

    // ------------------------------------------------------------
    // bus widths and register offsets
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] OPSTAT_ADDR = 8'h00;
    localparam logic [7:0] LOSS_CFG_ADDR = 8'h01;
    localparam logic [7:0] IRQ_STAT_ADDR = 8'h02;
    localparam logic [7:0] IRQ_MASK_ADDR = 8'h03;

    // ------------------------------------------------------------
    // operating status fields
    // ------------------------------------------------------------
    localparam int EXT_SYNC_BIT = 7;
    localparam int AUX_LOCK_BIT = 6;
    localparam int MAIN_SOFT_BIT = 5;
    localparam int AUX_SOFT_BIT = 4;
    localparam int MAIN_STATE_LSB = 0;
    localparam logic EXT_SYNC_RST = 1'h0;
    localparam logic MAIN_SOFT_RST = 1'h0;
    localparam logic AUX_SOFT_RST = 1'h0;

    // ------------------------------------------------------------
    // loss enable configuration fields
    // ------------------------------------------------------------
    localparam int CFG_FINE_BIT = 0;
    localparam int CFG_COARSE_BIT = 1;
    localparam int CFG_IDLE_BIT = 2;
    localparam int CFG_FREQ_BIT = 3;
    localparam int NUM_LOSS = 4;
    localparam logic [3:0] LOSS_CFG_RST = 4'hF;

    // ------------------------------------------------------------
    // interrupt events
    // ------------------------------------------------------------
    localparam int IRQ_AUX_UNLOCK = 0;
    localparam int IRQ_MAIN_SOFT = 1;
    localparam int IRQ_AUX_SOFT = 2;
    localparam int IRQ_EXT_SYNC = 3;
    localparam int IRQ_STATE_CHG = 4;
    localparam int NUM_EVT = 5;
    localparam logic [4:0] IRQ_STAT_RST = 5'h00;
    localparam logic [4:0] IRQ_MASK_RST = 5'h00;

    // ------------------------------------------------------------
    // state types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MS_UNUSED0 = 3'h0,
        MS_FREE = 3'h1,
        MS_HOLD = 3'h2,
        MS_UNUSED3 = 3'h3,
        MS_LOCK = 3'h4,
        MS_PRE2 = 3'h5,
        MS_PRE = 3'h6,
        MS_LOST = 3'h7
    } main_state_t;
    localparam main_state_t MAIN_STATE_RST = MS_FREE;

    typedef enum logic {
        AUX_UNLOCKED = 1'h0,
        AUX_LOCKED = 1'h1
    } aux_lock_t;
    localparam aux_lock_t AUX_LOCK_RST = AUX_LOCKED;

endpackage

// >>> loop_operating_status.sv
// loop operating status register with lock latch and interrupts
`timescale 1ns/100ps
// ----------------------------------------------------------------
// ----------------------------------------------------------------
module loop_operating_status
(
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // register port
    input wire logic [loop_status_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [loop_status_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [loop_status_pkg::DATA_W-1:0] reg_rdata,
    // aux loop loss indicators
    input wire logic fine_phase_loss,
    input wire logic coarse_phase_loss,
    input wire logic idle_input_loss,
    input wire logic freq_limit_loss,
    input wire logic aux_freq_hard_limit,
    // alarm and state inputs
    input wire logic main_loop_soft_alarm_in,
    input wire logic aux_loop_soft_alarm_in,
    input wire logic ext_sync_monitor_alarm_in,
    input wire logic [2:0] main_loop_state_in,
    // enables shared with the main loop
    output logic fine_loss_enable,
    output logic coarse_loss_enable,
    output logic idle_input_loss_enable,
    output logic freq_limit_loss_enable,
    // aux loop control and interrupt
    output logic aux_loop_tracking,
    output logic irq
);
    import loop_status_pkg::*;

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    logic wr_opstat;
    logic wr_cfg;
    logic wr_istat;
    logic wr_imask;
    logic clear_req;

    assign wr_opstat = reg_wr && (reg_addr == OPSTAT_ADDR);
    assign wr_cfg = reg_wr && (reg_addr == LOSS_CFG_ADDR);
    assign wr_istat = reg_wr && (reg_addr == IRQ_STAT_ADDR);
    assign wr_imask = reg_wr && (reg_addr == IRQ_MASK_ADDR);
    // only the lock clear bit of a status write has any effect
    assign clear_req = wr_opstat && reg_wdata[AUX_LOCK_BIT];

    // ------------------------------------------------------------
    // loss enable configuration
    // ------------------------------------------------------------
    logic [NUM_LOSS-1:0] loss_cfg_r;
    logic [NUM_LOSS-1:0] loss_cfg_nxt;

    always_comb
    begin
        loss_cfg_nxt = loss_cfg_r;
        if (wr_cfg)
        begin
            loss_cfg_nxt = reg_wdata[NUM_LOSS-1:0];
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            loss_cfg_r <= LOSS_CFG_RST;
        end
        else
        begin
            loss_cfg_r <= loss_cfg_nxt;
        end
    end

    // ------------------------------------------------------------
    // gated loss sources
    // ------------------------------------------------------------
    logic [NUM_LOSS-1:0] loss_raw;
    logic [NUM_LOSS-1:0] loss_gated;
    logic loss_now;

    assign loss_raw[CFG_FINE_BIT] = fine_phase_loss;
    assign loss_raw[CFG_COARSE_BIT] = coarse_phase_loss;
    assign loss_raw[CFG_IDLE_BIT] = idle_input_loss;
    assign loss_raw[CFG_FREQ_BIT] = freq_limit_loss;

    // each source passes only while its enable is set
    genvar gl;
    generate
        for (gl = 0; gl < NUM_LOSS; gl++)
        begin : g_loss
            assign loss_gated[gl] = loss_raw[gl] & loss_cfg_r[gl];
        end
    endgenerate

    assign loss_now = |loss_gated;

    // ------------------------------------------------------------
    // aux loop lock latch
    // ------------------------------------------------------------
    aux_lock_t aux_state_r;
    aux_lock_t aux_state_nxt;

    always_comb
    begin
        aux_state_nxt = aux_state_r;
        case (aux_state_r)
            AUX_LOCKED:
            begin
                if (loss_now)
                begin
                    aux_state_nxt = AUX_UNLOCKED;
                end
            end
            AUX_UNLOCKED:
            begin
                // clear only with coarse detector off and no loss present
                if (clear_req && !loss_cfg_r[CFG_COARSE_BIT] && !loss_now)
                begin
                    aux_state_nxt = AUX_LOCKED;
                end
            end
            default: aux_state_nxt = AUX_UNLOCKED;
        endcase
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            aux_state_r <= AUX_LOCK_RST;
        end
        else
        begin
            aux_state_r <= aux_state_nxt;
        end
    end

    // ------------------------------------------------------------
    // alarms, main loop state and tracking
    // ------------------------------------------------------------
    main_state_t main_state_r;
    main_state_t main_state_nxt;
    logic main_soft_r;
    logic main_soft_nxt;
    logic aux_soft_r;
    logic aux_soft_nxt;
    logic ext_sync_r;
    logic ext_sync_nxt;
    logic tracking_nxt;

    always_comb
    begin
        main_soft_nxt = main_loop_soft_alarm_in;
        aux_soft_nxt = aux_loop_soft_alarm_in;
        ext_sync_nxt = ext_sync_monitor_alarm_in;
        tracking_nxt = !aux_freq_hard_limit;
        main_state_nxt = main_state_r;
        case (main_loop_state_in)
            3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7:
            begin
                main_state_nxt = main_state_t'(main_loop_state_in);
            end
            default: main_state_nxt = main_state_r;
        endcase
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            main_state_r <= MAIN_STATE_RST;
            main_soft_r <= MAIN_SOFT_RST;
            aux_soft_r <= AUX_SOFT_RST;
            ext_sync_r <= EXT_SYNC_RST;
            aux_loop_tracking <= 1'h1;
        end
        else
        begin
            main_state_r <= main_state_nxt;
            main_soft_r <= main_soft_nxt;
            aux_soft_r <= aux_soft_nxt;
            ext_sync_r <= ext_sync_nxt;
            aux_loop_tracking <= tracking_nxt;
        end
    end

    // ------------------------------------------------------------
    // status byte
    // ------------------------------------------------------------
    logic [DATA_W-1:0] opstat;

    always_comb
    begin
        opstat = 8'h00;
        opstat[EXT_SYNC_BIT] = ext_sync_r;
        opstat[AUX_LOCK_BIT] = aux_state_r;
        opstat[MAIN_SOFT_BIT] = main_soft_r;
        opstat[AUX_SOFT_BIT] = aux_soft_r;
        opstat[MAIN_STATE_LSB+:3] = main_state_r;
    end

    // ------------------------------------------------------------
    // interrupt status and mask
    // ------------------------------------------------------------
    logic [NUM_EVT-1:0] evt;
    logic [NUM_EVT-1:0] istat_r;
    logic [NUM_EVT-1:0] istat_nxt;
    logic [NUM_EVT-1:0] imask_r;
    logic [NUM_EVT-1:0] imask_nxt;
    logic irq_nxt;

    assign evt[IRQ_AUX_UNLOCK] = (aux_state_r == AUX_LOCKED) && (aux_state_nxt == AUX_UNLOCKED);
    assign evt[IRQ_MAIN_SOFT] = main_soft_nxt && !main_soft_r;
    assign evt[IRQ_AUX_SOFT] = aux_soft_nxt && !aux_soft_r;
    assign evt[IRQ_EXT_SYNC] = ext_sync_nxt && !ext_sync_r;
    assign evt[IRQ_STATE_CHG] = main_state_nxt != main_state_r;

    // a new event wins over a write-one clear in the same cycle
    genvar gi;
    generate
        for (gi = 0; gi < NUM_EVT; gi++)
        begin : g_irq
            assign istat_nxt[gi] = evt[gi] | (istat_r[gi] & ~(wr_istat & reg_wdata[gi]));
        end
    endgenerate

    always_comb
    begin
        imask_nxt = imask_r;
        if (wr_imask)
        begin
            imask_nxt = reg_wdata[NUM_EVT-1:0];
        end
        irq_nxt = |(istat_nxt & imask_nxt);
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            istat_r <= IRQ_STAT_RST;
            imask_r <= IRQ_MASK_RST;
            irq <= 1'h0;
        end
        else
        begin
            istat_r <= istat_nxt;
            imask_r <= imask_nxt;
            irq <= irq_nxt;
        end
    end

    // ------------------------------------------------------------
    // read data and enable outputs
    // ------------------------------------------------------------
    logic [DATA_W-1:0] rdata_nxt;

    always_comb
    begin
        rdata_nxt = 8'h00;
        if (reg_rd)
        begin
            case (reg_addr)
                OPSTAT_ADDR: rdata_nxt = opstat;
                LOSS_CFG_ADDR: rdata_nxt = {4'h0, loss_cfg_r};
                IRQ_STAT_ADDR: rdata_nxt = {3'h0, istat_r};
                IRQ_MASK_ADDR: rdata_nxt = {3'h0, imask_r};
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            reg_rdata <= 8'h00;
            fine_loss_enable <= LOSS_CFG_RST[CFG_FINE_BIT];
            coarse_loss_enable <= LOSS_CFG_RST[CFG_COARSE_BIT];
            idle_input_loss_enable <= LOSS_CFG_RST[CFG_IDLE_BIT];
            freq_limit_loss_enable <= LOSS_CFG_RST[CFG_FREQ_BIT];
        end
        else
        begin
            reg_rdata <= rdata_nxt;
            fine_loss_enable <= loss_cfg_nxt[CFG_FINE_BIT];
            coarse_loss_enable <= loss_cfg_nxt[CFG_COARSE_BIT];
            idle_input_loss_enable <= loss_cfg_nxt[CFG_IDLE_BIT];
            freq_limit_loss_enable <= loss_cfg_nxt[CFG_FREQ_BIT];
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    a_loss_drops_lock: assert property (loss_now |=> aux_state_r == AUX_UNLOCKED)
        else $error("gated loss did not drop lock");

    a_fine_gated: assert property (
        aux_state_r == AUX_LOCKED && !loss_cfg_r[CFG_FINE_BIT] && fine_phase_loss
        && !coarse_phase_loss && !idle_input_loss && !freq_limit_loss
        |=> aux_state_r == AUX_LOCKED)
        else $error("disabled fine loss dropped lock");

    a_coarse_gated: assert property (
        aux_state_r == AUX_LOCKED && !loss_cfg_r[CFG_COARSE_BIT] && coarse_phase_loss
        && !fine_phase_loss && !idle_input_loss && !freq_limit_loss
        |=> aux_state_r == AUX_LOCKED)
        else $error("disabled coarse loss dropped lock");

    a_idle_gated: assert property (
        aux_state_r == AUX_LOCKED && !loss_cfg_r[CFG_IDLE_BIT] && idle_input_loss
        && !fine_phase_loss && !coarse_phase_loss && !freq_limit_loss
        |=> aux_state_r == AUX_LOCKED)
        else $error("disabled idle loss dropped lock");

    a_freq_gated: assert property (
        aux_state_r == AUX_LOCKED && !loss_cfg_r[CFG_FREQ_BIT] && freq_limit_loss
        && !fine_phase_loss && !coarse_phase_loss && !idle_input_loss
        |=> aux_state_r == AUX_LOCKED)
        else $error("disabled limit loss dropped lock");

    a_unlock_latches: assert property (
        aux_state_r == AUX_UNLOCKED && !clear_req |=> aux_state_r == AUX_UNLOCKED)
        else $error("unlock released without clear");

    a_clear_needs_coarse: assert property (
        aux_state_r == AUX_UNLOCKED && loss_cfg_r[CFG_COARSE_BIT]
        |=> aux_state_r == AUX_UNLOCKED)
        else $error("clear honoured with coarse enabled");

    a_clear_relocks: assert property (
        aux_state_r == AUX_UNLOCKED && clear_req && !loss_cfg_r[CFG_COARSE_BIT] && !loss_now
        |=> aux_state_r == AUX_LOCKED)
        else $error("valid clear sequence ignored");

    a_relock_clean: assert property (
        $rose(aux_state_r) |-> !$past(loss_now))
        else $error("relock while loss present");

    a_main_soft: assert property (##1 main_soft_r == $past(main_loop_soft_alarm_in))
        else $error("main soft alarm not tracked");

    a_aux_track: assert property (aux_freq_hard_limit |=> !aux_loop_tracking)
        else $error("tracking kept past hard limit");

    a_aux_soft: assert property (##1 aux_soft_r == $past(aux_loop_soft_alarm_in))
        else $error("aux soft alarm not tracked");

    a_state_code_ok: assert property (main_state_r != MS_UNUSED0 && main_state_r != MS_UNUSED3)
        else $error("unused main state code reported");

    a_state_follow: assert property (
        main_loop_state_in == 3'h4 |=> main_state_r == MS_LOCK)
        else $error("main state not tracked");

    a_ext_sync: assert property (##1 ext_sync_r == $past(ext_sync_monitor_alarm_in))
        else $error("sync alarm not tracked");

    a_read_opstat: assert property (
        reg_rd && reg_addr == OPSTAT_ADDR
        |=> reg_rdata[3] == 1'h0 && reg_rdata[AUX_LOCK_BIT] == $past(aux_state_r)
        && reg_rdata[2:0] == $past(main_state_r))
        else $error("status read data wrong");

    c_lock_lost: cover property (aux_state_r == AUX_LOCKED ##1 aux_state_r == AUX_UNLOCKED);
    c_relock: cover property (aux_state_r == AUX_UNLOCKED ##1 aux_state_r == AUX_LOCKED);
    c_state_chg: cover property (main_state_r == MS_FREE ##[1:20] main_state_r == MS_LOCK);
    c_irq: cover property (!irq ##1 irq);

endmodule

// >>> tb.sv
// self-checking testbench for the loop operating status register block
`timescale 1ns/100ps
module tb;
    import loop_status_pkg::*;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic core_clk = 1'h0;
    logic resetn = 1'h0;
    logic [ADDR_W-1:0] reg_addr = 8'h00;
    logic [DATA_W-1:0] reg_wdata = 8'h00;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic [DATA_W-1:0] reg_rdata;
    logic [3:0] loss_v = 4'h0;
    logic hard_lim = 1'h0;
    logic main_soft = 1'h0;
    logic aux_soft = 1'h0;
    logic ext_alarm = 1'h0;
    logic [2:0] state_in = 3'h1;
    logic [3:0] en_out;
    logic tracking;
    logic irq;
    int n_mismatch = 0;
    int checked = 0;
    logic [7:0] codes [6] = '{8'h01, 8'h02, 8'h04, 8'h05, 8'h06, 8'h07};

    always #12.5 core_clk = ~core_clk;

    loop_operating_status i_dut
    (
        .core_clk(core_clk),
        .resetn(resetn),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .fine_phase_loss(loss_v[0]),
        .coarse_phase_loss(loss_v[1]),
        .idle_input_loss(loss_v[2]),
        .freq_limit_loss(loss_v[3]),
        .aux_freq_hard_limit(hard_lim),
        .main_loop_soft_alarm_in(main_soft),
        .aux_loop_soft_alarm_in(aux_soft),
        .ext_sync_monitor_alarm_in(ext_alarm),
        .main_loop_state_in(state_in),
        .fine_loss_enable(en_out[0]),
        .coarse_loss_enable(en_out[1]),
        .idle_input_loss_enable(en_out[2]),
        .freq_limit_loss_enable(en_out[3]),
        .aux_loop_tracking(tracking),
        .irq(irq)
    );

    // ------------------------------------------------------------
    // bus tasks and compare
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge core_clk);
        reg_wr <= 1'h1;
        reg_addr <= addr;
        reg_wdata <= data;
        @(posedge core_clk);
        reg_wr <= 1'h0;
    endtask

    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
        @(posedge core_clk);
        reg_rd <= 1'h1;
        reg_addr <= addr;
        @(posedge core_clk);
        reg_rd <= 1'h0;
        @(negedge core_clk);
        chk(reg_rdata, exp);
    endtask

    task automatic settle();
        repeat (2) @(negedge core_clk);
    endtask

    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------
    initial
    begin
        repeat (4000) @(posedge core_clk);
        n_mismatch++;
        close_out();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial
    begin
        repeat (6) @(posedge core_clk);
        resetn <= 1'h1;
        // reset values and unmapped address
        rd_chk(OPSTAT_ADDR, 8'h41);
        rd_chk(LOSS_CFG_ADDR, 8'h0F);
        rd_chk(IRQ_STAT_ADDR, 8'h00);
        rd_chk(IRQ_MASK_ADDR, 8'h00);
        rd_chk(8'h55, 8'h00);
        chk({4'h0, en_out}, 8'h0F);
        chk({7'h00, tracking}, 8'h01);
        chk({7'h00, irq}, 8'h00);
        $display("test reset done");

        // alarm bits, write to status ignored
        @(posedge core_clk);
        ext_alarm <= 1'h1;
        main_soft <= 1'h1;
        aux_soft <= 1'h1;
        wr(OPSTAT_ADDR, 8'hFF);
        rd_chk(OPSTAT_ADDR, 8'hF1);
        @(posedge core_clk);
        ext_alarm <= 1'h0;
        main_soft <= 1'h0;
        aux_soft <= 1'h0;
        rd_chk(OPSTAT_ADDR, 8'h41);
        rd_chk(IRQ_STAT_ADDR, 8'h0E);
        wr(IRQ_STAT_ADDR, 8'h1F);
        rd_chk(IRQ_STAT_ADDR, 8'h00);
        $display("test alarms done");

        // main loop state codes, unused codes hold
        foreach (codes[k])
        begin
            @(posedge core_clk);
            state_in <= codes[k][2:0];
            rd_chk(OPSTAT_ADDR, 8'h40 | codes[k]);
        end
        @(posedge core_clk);
        state_in <= 3'h0;
        rd_chk(OPSTAT_ADDR, 8'h47);
        @(posedge core_clk);
        state_in <= 3'h3;
        rd_chk(OPSTAT_ADDR, 8'h47);
        @(posedge core_clk);
        state_in <= 3'h1;
        rd_chk(OPSTAT_ADDR, 8'h41);
        rd_chk(IRQ_STAT_ADDR, 8'h10);
        wr(IRQ_STAT_ADDR, 8'h10);
        $display("test states done");

        // each loss source gated, latched, then cleared
        for (int i = 0; i < NUM_LOSS; i++)
        begin
            wr(LOSS_CFG_ADDR, 8'h0F & ~(8'h01 << i));
            settle();
            chk({4'h0, en_out}, 8'h0F & ~(8'h01 << i));
            @(posedge core_clk);
            loss_v <= 4'h1 << i;
            rd_chk(OPSTAT_ADDR, 8'h41);
            @(posedge core_clk);
            loss_v <= 4'h0;
            wr(LOSS_CFG_ADDR, 8'h0F);
            @(posedge core_clk);
            loss_v <= 4'h1 << i;
            rd_chk(OPSTAT_ADDR, 8'h01);
            @(posedge core_clk);
            loss_v <= 4'h0;
            rd_chk(OPSTAT_ADDR, 8'h01);
            wr(OPSTAT_ADDR, 8'h40);
            rd_chk(OPSTAT_ADDR, 8'h01);
            wr(LOSS_CFG_ADDR, 8'h0D);
            wr(OPSTAT_ADDR, 8'h40);
            wr(LOSS_CFG_ADDR, 8'h0F);
            rd_chk(OPSTAT_ADDR, 8'h41);
        end
        $display("test loss gating done");

        // interrupt raised, masked, cleared
        rd_chk(IRQ_STAT_ADDR, 8'h01);
        chk({7'h00, irq}, 8'h00);
        wr(IRQ_MASK_ADDR, 8'h01);
        settle();
        chk({7'h00, irq}, 8'h01);
        rd_chk(IRQ_MASK_ADDR, 8'h01);
        wr(IRQ_STAT_ADDR, 8'h01);
        settle();
        chk({7'h00, irq}, 8'h00);
        rd_chk(IRQ_STAT_ADDR, 8'h00);
        $display("test interrupt done");

        // tracking stops at the hard limit
        @(posedge core_clk);
        hard_lim <= 1'h1;
        settle();
        chk({7'h00, tracking}, 8'h00);
        @(posedge core_clk);
        hard_lim <= 1'h0;
        settle();
        chk({7'h00, tracking}, 8'h01);
        $display("test tracking done");
        close_out();
    end
endmodule
